/* design/chip_select_pins.sv */
// Chip-select decode, float test mode and transceiver control pins
`timescale 1ns/1ps
`default_nettype none
module chip_select_pins #(
  parameter int ADDR_W = cs_pins_pkg::ADDR_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              coldStartInN,
  input  wire logic              cycleStart,
  input  wire logic              cycleActive,
  input  wire logic              dataPhase,
  input  wire logic [ADDR_W-1:0] cycleAddr,
  input  wire logic              cycleIsMem,
  input  wire logic              cycleWrite,
  input  wire logic              cycleIsCoproc,
  input  wire logic              holdGrant,
  input  wire logic              extendedMode,
  input  wire logic [4:0]        upperSizeLog,
  input  wire logic [4:0]        lowerSizeLog,
  input  wire logic [ADDR_W-1:0] midBase,
  input  wire logic [4:0]        midSizeLog,
  input  wire logic [ADDR_W-1:0] periphBase,
  input  wire logic              periphInMem,
  input  wire logic              sel5IsAddr,
  input  wire logic              sel6IsAddr,
  input  wire logic              upperMemSelectIn,
  input  wire logic              lowerMemSelectIn,
  input  wire logic [1:0]        midMemSelectIn,
  output logic                   upperMemSelectN,
  output logic                   upperMemSelectOe,
  output logic                   upperPullupEn,
  output logic                   lowerMemSelectN,
  output logic                   lowerMemSelectOe,
  output logic                   lowerPullupEn,
  output logic [3:0]             midMemSelectN,
  output logic [3:0]             midMemSelectOe,
  output logic [4:0]             periphSelectN,
  output logic [4:0]             periphSelectOe,
  output logic                   periphSel5OrLatchedAddr1,
  output logic                   periphSel5Oe,
  output logic                   periphSel6OrLatchedAddr2,
  output logic                   periphSel6Oe,
  output logic                   xcvrDirection,
  output logic                   xcvrDirectionOe,
  output logic                   xcvrOutputEnableN,
  output logic                   xcvrOutputEnableOe,
  output logic                   allPinsFloatTestMode,
  output logic                   coprocTransferRequest,
  output logic                   coprocError
);
  // ==========================================================
  // Elaboration checks
  generate
    if (ADDR_W != cs_pins_pkg::ADDR_W)
    begin : g_bad_addr
      $error("chip_select_pins decodes a 20-bit address only");
    end
  endgenerate

  // ==========================================================
  // Helpers
  function automatic logic [4:0] clampLog(
    input logic [4:0] v,
    input logic [4:0] lo,
    input logic [4:0] hi
  );
    clampLog = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [cs_pins_pkg::SYNC_W-1:0] pinRaw;
  logic [cs_pins_pkg::SYNC_W-1:0] pinSync;
  logic                           coldPrev_reg;
  logic                           inReset;
  logic                           resetRelease;

  assign pinRaw = {midMemSelectIn[1], midMemSelectIn[0], lowerMemSelectIn,
                   upperMemSelectIn, coldStartInN};

  pin_sync #(.WIDTH(cs_pins_pkg::SYNC_W)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pinIn    (pinRaw),
    .pinSync  (pinSync)
  );

  assign inReset      = !pinSync[cs_pins_pkg::SYNC_COLD];
  assign resetRelease = pinSync[cs_pins_pkg::SYNC_COLD] && !coldPrev_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      coldPrev_reg <= 1'b0;
    else
      coldPrev_reg <= pinSync[cs_pins_pkg::SYNC_COLD];
  end

  // ==========================================================
  // Float test mode
  logic floatMode;
  assign floatMode = allPinsFloatTestMode;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      allPinsFloatTestMode <= 1'b0;
    else if (inReset)
      allPinsFloatTestMode <= 1'b0;
    else if (resetRelease)
      allPinsFloatTestMode <= !pinSync[cs_pins_pkg::SYNC_UPPER]
                           && !pinSync[cs_pins_pkg::SYNC_LOWER];
  end

  // Pull-ups keep a floating pin from looking like a float request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upperPullupEn <= 1'b1;
      lowerPullupEn <= 1'b1;
    end
    else
    begin
      upperPullupEn <= inReset && !floatMode;
      lowerPullupEn <= inReset && !floatMode;
    end
  end

  // ==========================================================
  // Address decode
  logic [ADDR_W-1:0] periphAddr;
  logic [4:0]        upperLog;
  logic [4:0]        lowerLog;
  logic [4:0]        midLog;
  logic [ADDR_W-1:0] midShift;
  logic [1:0]        midIdx;
  logic [2:0]        periphIdx;
  logic              upperHit;
  logic              lowerHit;
  logic              midHit;
  logic              periphHit;
  logic              busOwned;

  assign upperLog   = clampLog(upperSizeLog, cs_pins_pkg::EDGE_LOG_MIN,
                               cs_pins_pkg::EDGE_LOG_MAX);
  assign lowerLog   = clampLog(lowerSizeLog, cs_pins_pkg::EDGE_LOG_MIN,
                               cs_pins_pkg::EDGE_LOG_MAX);
  assign midLog     = clampLog(midSizeLog, cs_pins_pkg::MID_LOG_MIN,
                               cs_pins_pkg::MID_LOG_MAX);
  // I/O space has only 16 address bits
  assign periphAddr = periphInMem ? cycleAddr
    : {{(ADDR_W-cs_pins_pkg::IO_ADDR_W){1'b0}},
       cycleAddr[cs_pins_pkg::IO_ADDR_W-1:0]};
  assign midShift   = cycleAddr >> (midLog - cs_pins_pkg::MID_IDX_SHIFT);
  assign midIdx     = midShift[1:0];
  assign periphIdx  = periphAddr[cs_pins_pkg::PERIPH_IDX_LSB +: 3];
  // Hold request is kept high by the other master until it is done
  assign busOwned   = cycleActive && !holdGrant;

  range_hit #(.ADDR_W(ADDR_W)) u_upper (
    .addrIn  (cycleAddr),
    .baseIn  ('1),
    .sizeLog (upperLog),
    .hit     (upperHit)
  );
  range_hit #(.ADDR_W(ADDR_W)) u_lower (
    .addrIn  (cycleAddr),
    .baseIn  ('0),
    .sizeLog (lowerLog),
    .hit     (lowerHit)
  );
  range_hit #(.ADDR_W(ADDR_W)) u_mid (
    .addrIn  (cycleAddr),
    .baseIn  (midBase),
    .sizeLog (midLog),
    .hit     (midHit)
  );
  range_hit #(.ADDR_W(ADDR_W)) u_periph (
    .addrIn  (periphAddr),
    .baseIn  (periphBase),
    .sizeLog (cs_pins_pkg::PERIPH_BLOCK_LOG),
    .hit     (periphHit)
  );

  // ==========================================================
  // Memory selects
  logic drivePins;
  assign drivePins = !floatMode && !inReset;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upperMemSelectN  <= cs_pins_pkg::SELECT_IDLE;
      lowerMemSelectN  <= cs_pins_pkg::SELECT_IDLE;
      upperMemSelectOe <= 1'b0;
      lowerMemSelectOe <= 1'b0;
    end
    else
    begin
      upperMemSelectN  <= !(busOwned && cycleIsMem && upperHit);
      lowerMemSelectN  <= !(busOwned && cycleIsMem && lowerHit);
      upperMemSelectOe <= drivePins;
      lowerMemSelectOe <= drivePins;
    end
  end

  // Extended mode gives pins 0, 1 and 3 to the coprocessor
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      midMemSelectN  <= '1;
      midMemSelectOe <= '0;
    end
    else
    begin
      for (int i = 0; i < cs_pins_pkg::MID_COUNT; i++)
        midMemSelectN[i] <= !(busOwned && cycleIsMem && midHit
                              && midIdx == 2'(i));
      if (extendedMode)
        midMemSelectN[3] <= !(busOwned && cycleIsCoproc);
      midMemSelectOe[0] <= drivePins && !extendedMode;
      midMemSelectOe[1] <= drivePins && !extendedMode;
      midMemSelectOe[2] <= drivePins;
      midMemSelectOe[3] <= drivePins;
    end
  end

  // Coprocessor inputs; the error pin is active low
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coprocTransferRequest <= 1'b0;
      coprocError           <= 1'b0;
    end
    else
    begin
      coprocTransferRequest <= extendedMode
                            && pinSync[cs_pins_pkg::SYNC_REQ];
      coprocError           <= extendedMode
                            && !pinSync[cs_pins_pkg::SYNC_ERR];
    end
  end

  // ==========================================================
  // Peripheral selects and latched address bits
  logic [1:0] latchedAddr_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      latchedAddr_reg <= 2'h0;
    else if (cycleStart && !holdGrant)
      latchedAddr_reg <= cycleAddr[2:1];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      periphSelectN            <= '1;
      periphSelectOe           <= '0;
      periphSel5OrLatchedAddr1 <= cs_pins_pkg::SELECT_IDLE;
      periphSel6OrLatchedAddr2 <= cs_pins_pkg::SELECT_IDLE;
      periphSel5Oe             <= 1'b0;
      periphSel6Oe             <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < cs_pins_pkg::PERIPH_COUNT; i++)
        periphSelectN[i] <= !(busOwned && periphHit
                              && cycleIsMem == periphInMem
                              && periphIdx == 3'(i));
      periphSelectOe <= {cs_pins_pkg::PERIPH_COUNT{!floatMode}};
      if (inReset)
      begin
        periphSel5OrLatchedAddr1 <= cs_pins_pkg::SELECT_IDLE;
        periphSel6OrLatchedAddr2 <= cs_pins_pkg::SELECT_IDLE;
      end
      else
      begin
        periphSel5OrLatchedAddr1 <= sel5IsAddr ? latchedAddr_reg[0]
          : !(busOwned && periphHit && cycleIsMem == periphInMem
              && periphIdx == 3'h5);
        periphSel6OrLatchedAddr2 <= sel6IsAddr ? latchedAddr_reg[1]
          : !(busOwned && periphHit && cycleIsMem == periphInMem
              && periphIdx == 3'h6);
      end
      periphSel5Oe <= !floatMode;
      periphSel6Oe <= !floatMode;
    end
  end

  // ==========================================================
  // Transceiver control
  logic dirChange;
  logic denResetDone_reg;

  // Enable is forced off in the very edge that flips direction
  assign dirChange = busOwned && (cycleWrite != xcvrDirection);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xcvrDirection   <= cs_pins_pkg::DIR_RESET;
      xcvrDirectionOe <= 1'b0;
    end
    else
    begin
      if (inReset)
        xcvrDirection <= cs_pins_pkg::DIR_RESET;
      else if (busOwned)
        xcvrDirection <= cycleWrite;
      xcvrDirectionOe <= drivePins && !holdGrant;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      denResetDone_reg <= 1'b0;
    else
      denResetDone_reg <= inReset;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xcvrOutputEnableN  <= cs_pins_pkg::DEN_RESET;
      xcvrOutputEnableOe <= 1'b1;
    end
    else if (inReset)
    begin
      xcvrOutputEnableN  <= cs_pins_pkg::DEN_RESET;
      xcvrOutputEnableOe <= !denResetDone_reg && !floatMode;
    end
    else
    begin
      xcvrOutputEnableN  <= !(busOwned && dataPhase && !dirChange);
      xcvrOutputEnableOe <= !floatMode && !holdGrant;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_upper_decode: assert property (busOwned && cycleIsMem && upperHit
    |=> !upperMemSelectN)
    else $error("upper select missed a top hit");
  a_lower_decode: assert property (busOwned && cycleIsMem && lowerHit
    |=> !lowerMemSelectN)
    else $error("lower select missed a bottom hit");
  a_mid_decode: assert property (!extendedMode && busOwned && cycleIsMem
    && midHit |=> $countones(~midMemSelectN) == 1)
    else $error("mid window hit did not pick one select");
  a_float_entry: assert property (resetRelease
    && !pinSync[cs_pins_pkg::SYNC_UPPER] && !pinSync[cs_pins_pkg::SYNC_LOWER]
    |=> allPinsFloatTestMode ##1 !upperMemSelectOe && !periphSel5Oe)
    else $error("float test entry not honoured");
  a_float_all_z: assert property (allPinsFloatTestMode && !inReset |=>
    !(|{upperMemSelectOe, lowerMemSelectOe, midMemSelectOe, periphSelectOe,
        periphSel5Oe, periphSel6Oe, xcvrDirectionOe,
        xcvrOutputEnableOe}))
    else $error("pin driven in float test mode");
  a_pullup_reset: assert property (!(inReset && floatMode)
    |=> {upperPullupEn, lowerPullupEn} == {2{$past(inReset)}})
    else $error("pull-up not tied to cold start");
  a_copro_pins: assert property (extendedMode [*2]
    |-> !midMemSelectOe[0] && !midMemSelectOe[1])
    else $error("coprocessor input pin still driven");
  a_nps_select: assert property (extendedMode && $past(extendedMode)
    && !midMemSelectN[3] |-> $past(busOwned && cycleIsCoproc))
    else $error("numeric select without coprocessor access");
  a_periph_decode: assert property (busOwned && periphHit
    && cycleIsMem == periphInMem && periphIdx < 3'h5
    |=> $countones(~periphSelectN) == 1)
    else $error("peripheral hit did not pick one select");
  a_addr_hold: assert property (sel5IsAddr && holdGrant && !inReset
    && !floatMode ##1 sel5IsAddr && holdGrant
    |=> periphSel5Oe && $stable(periphSel5OrLatchedAddr1))
    else $error("latched address moved during hold");
  a_dir_follow: assert property (busOwned && !inReset
    |=> xcvrDirection == $past(cycleWrite))
    else $error("direction does not follow access");
  a_den_change: assert property ($changed(xcvrDirection)
    |-> xcvrOutputEnableN)
    else $error("enable low while direction changed");
  a_den_reset: assert property ($fell(pinSync[cs_pins_pkg::SYNC_COLD])
    && !floatMode |=> xcvrOutputEnableOe && xcvrOutputEnableN
    ##1 (!inReset || !xcvrOutputEnableOe))
    else $error("enable reset pulse wrong");
  a_dir_float: assert property (holdGrant || inReset
    |=> !xcvrDirectionOe)
    else $error("direction driven in hold or reset");

  c_float_mode: cover property (resetRelease ##1 allPinsFloatTestMode);
  c_write_read: cover property (busOwned && cycleWrite
    ##[1:8] busOwned && !cycleWrite);
  c_hold_latch: cover property ((sel5IsAddr && holdGrant) [*3]);
endmodule // chip_select_pins
`default_nettype wire

/* design/cs_pins_pkg.sv */
// Shared constants for the chip-select and transceiver pin block
package cs_pins_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W       = 20;
  localparam int IO_ADDR_W    = 16;
  localparam int LOG_W        = 5;
  localparam int MID_COUNT    = 4;
  localparam int PERIPH_COUNT = 5;
  localparam int SYNC_W       = 5;
  // ==========================================================
  // Region size limits, as log2 of bytes
  localparam logic [4:0] EDGE_LOG_MIN     = 5'h0a;  // 1K
  localparam logic [4:0] EDGE_LOG_MAX     = 5'h12;  // 256K
  localparam logic [4:0] MID_LOG_MIN      = 5'h0d;  // 8K
  localparam logic [4:0] MID_LOG_MAX      = 5'h13;  // 512K
  localparam logic [4:0] PERIPH_BLOCK_LOG = 5'h0a;  // 1K holds 7 selects
  localparam logic [4:0] MID_IDX_SHIFT    = 5'h02;
  localparam int         PERIPH_IDX_LSB   = 7;      // 128 bytes a select
  // ==========================================================
  // Synchroniser bit positions
  localparam int SYNC_COLD  = 0;
  localparam int SYNC_UPPER = 1;
  localparam int SYNC_LOWER = 2;
  localparam int SYNC_REQ   = 3;
  localparam int SYNC_ERR   = 4;
  // ==========================================================
  // Reset values
  localparam logic SELECT_IDLE = 1'b1;
  localparam logic DIR_RESET   = 1'b0;
  localparam logic DEN_RESET   = 1'b1;
endpackage : cs_pins_pkg

/* design/pin_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("pin_sync needs WIDTH of at least one");
    end
  endgenerate

  // First stage is read by the second stage only
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign pinSync = stage2_reg;
endmodule // pin_sync
`default_nettype wire

/* design/range_hit.sv */
// Aligned power-of-two address window compare
`timescale 1ns/1ps
`default_nettype none
module range_hit #(
  parameter int ADDR_W = 20
) (
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [ADDR_W-1:0] baseIn,
  input  wire logic [4:0]        sizeLog,
  output logic                   hit
);
  logic [ADDR_W-1:0] diff;

  // Base bits below the window size are ignored
  assign diff = (addrIn ^ baseIn) >> sizeLog;
  assign hit  = (diff == '0);
endmodule // range_hit
`default_nettype wire

/* tb/pin_partner.sv */
// Model of the parts wired to the edge-select pins and mid-select pins 0 and 1
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic       clk_sys,
  input  wire logic       upperN,
  input  wire logic       upperOe,
  input  wire logic       upperPu,
  input  wire logic       lowerN,
  input  wire logic       lowerOe,
  input  wire logic       lowerPu,
  input  wire logic [1:0] midN,
  input  wire logic [1:0] midOe,
  input  wire logic       strapLow,
  input  wire logic       coprocReq,
  input  wire logic       coprocErrN,
  output logic            upperIn,
  output logic            lowerIn,
  output logic [1:0]      midIn
);
  // ==========================================================
  // Pin levels
  logic flip = 1'b0;
  // A line nobody drives or pulls wanders instead of settling
  always @(posedge clk_sys) flip <= ~flip;
  always_comb
  begin
    upperIn = upperOe ? upperN : strapLow ? 1'b0 : upperPu | flip;
    lowerIn = lowerOe ? lowerN : strapLow ? 1'b0 : lowerPu | flip;
    midIn[0] = midOe[0] ? midN[0] : coprocReq;
    midIn[1] = midOe[1] ? midN[1] : coprocErrN;
  end
endmodule // pin_partner
`default_nettype wire

/* tb/tb_chip_select_pins.sv */
// Self-checking bench for the chip-select and transceiver pin block
`timescale 1ns/1ps
`default_nettype none
module tb_chip_select_pins;
  // ==========================================================
  // Signals
  logic clk_sys = 0, rst_n = 0, coldStartInN = 0, cycleStart = 0;
  logic cycleActive = 0, dataPhase = 0, cycleIsMem = 0, cycleWrite = 0;
  logic cycleIsCoproc = 0, holdGrant = 0, extendedMode = 0;
  logic periphInMem = 0, sel5IsAddr = 0, sel6IsAddr = 1;
  logic [19:0] cycleAddr = 0, midBase = 20'h80000, periphBase = 20'h01400;
  logic [4:0] upperSizeLog = 5'h0a, lowerSizeLog = 5'h12;
  logic [4:0] midSizeLog = 5'h0d;
  logic upperMemSelectIn, lowerMemSelectIn, upperMemSelectN;
  logic upperMemSelectOe, upperPullupEn, lowerMemSelectN, lowerMemSelectOe;
  logic lowerPullupEn, periphSel5OrLatchedAddr1, periphSel5Oe;
  logic periphSel6OrLatchedAddr2, periphSel6Oe, xcvrDirection;
  logic xcvrDirectionOe, xcvrOutputEnableN, xcvrOutputEnableOe;
  logic allPinsFloatTestMode, coprocTransferRequest, coprocError;
  logic [1:0] midMemSelectIn;
  logic [3:0] midMemSelectN, midMemSelectOe;
  logic [4:0] periphSelectN, periphSelectOe;
  logic strapLow = 0, coprocReq = 0, coprocErrN = 1, dirSeen = 0;
  logic dirExp = 0;
  logic [31:0] seed = 32'hd, r;
  logic [19:0] a;
  int n_errors = 0, check_count = 0, cycles = 0;

  chip_select_pins dut (.clk_sys, .rst_n, .coldStartInN, .cycleStart,
    .cycleActive, .dataPhase, .cycleAddr, .cycleIsMem, .cycleWrite,
    .cycleIsCoproc, .holdGrant, .extendedMode, .upperSizeLog,
    .lowerSizeLog, .midBase, .midSizeLog, .periphBase, .periphInMem,
    .sel5IsAddr, .sel6IsAddr, .upperMemSelectIn, .lowerMemSelectIn,
    .midMemSelectIn, .upperMemSelectN, .upperMemSelectOe, .upperPullupEn,
    .lowerMemSelectN, .lowerMemSelectOe, .lowerPullupEn, .midMemSelectN,
    .midMemSelectOe, .periphSelectN, .periphSelectOe,
    .periphSel5OrLatchedAddr1, .periphSel5Oe, .periphSel6OrLatchedAddr2,
    .periphSel6Oe, .xcvrDirection, .xcvrDirectionOe, .xcvrOutputEnableN,
    .xcvrOutputEnableOe, .allPinsFloatTestMode, .coprocTransferRequest,
    .coprocError);
  pin_partner far (.clk_sys, .upperN(upperMemSelectN),
    .upperOe(upperMemSelectOe), .upperPu(upperPullupEn),
    .lowerN(lowerMemSelectN), .lowerOe(lowerMemSelectOe),
    .lowerPu(lowerPullupEn), .midN(midMemSelectN[1:0]),
    .midOe(midMemSelectOe[1:0]), .strapLow, .coprocReq, .coprocErrN,
    .upperIn(upperMemSelectIn), .lowerIn(lowerMemSelectIn),
    .midIn(midMemSelectIn));

  // ==========================================================
  // Helpers
  always #20 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [19:0] seen,
                     input logic [19:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      results();
    end
    #1;
    if (xcvrDirectionOe && dirSeen !== xcvrDirection)
      chk("denFlip", xcvrOutputEnableN, 1'b1);
    dirSeen = xcvrDirection;
  end
  // Reference model of one bus cycle, checked against the pins
  task automatic step(input logic [19:0] a, input logic mem, wr, act);
    logic [3:0] m;
    logic [4:0] p;
    int mi, pi;
    logic ph;
    @(posedge clk_sys);
    cycleAddr <= a;
    cycleIsMem <= mem;
    cycleWrite <= wr;
    cycleActive <= act;
    dataPhase <= act;
    cycleStart <= 1;
    m = 4'hf;
    p = 5'h1f;
    // Direction only follows owned cycles; idle steps keep the old level
    if (act)
      dirExp = wr;
    mi = 32'(a >> (midSizeLog - 5'h02)) & 3;
    pi = a[9:7];
    ph = act && mem == periphInMem && a[19:10] == periphBase[19:10];
    if (act && mem && (a >> midSizeLog) == (midBase >> midSizeLog))
      m[mi] = 0;
    if (ph && pi < 5)
      p[pi] = 0;
    @(posedge clk_sys);
    cycleStart <= 0;
    #1;
    chk("upper", upperMemSelectN, !(act && mem && (a >> upperSizeLog)
        == (20'hfffff >> upperSizeLog)));
    chk("lower", lowerMemSelectN, !(act && mem &&
        (a >> lowerSizeLog) == 0));
    chk("mid", midMemSelectN, m);
    chk("periph", periphSelectN, p);
    chk("dir", xcvrDirection, dirExp);
    @(posedge clk_sys);
    #1;
    chk("den", xcvrOutputEnableN, !act);
    chk("sel5", periphSel5OrLatchedAddr1,
        sel5IsAddr ? a[1] : !(ph && pi == 5));
    chk("addr2", periphSel6OrLatchedAddr2,
        sel6IsAddr ? a[2] : !(ph && pi == 6));
  endtask
  task automatic cold(input logic strap);
    @(posedge clk_sys);
    coldStartInN <= 0;
    strapLow <= strap;
    dirExp = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk("pullup", {upperPullupEn, lowerPullupEn}, 2'h3);
    chk("dirOe", xcvrDirectionOe, 1'b0);
    chk("denOe", xcvrOutputEnableOe, 1'b0);
    @(posedge clk_sys);
    coldStartInN <= 1;
    repeat (6) @(posedge clk_sys);
    strapLow <= 0;
    #1;
    chk("float", allPinsFloatTestMode, strap);
    chk("pulloff", {upperPullupEn, lowerPullupEn}, 2'h0);
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1;
    cold(1'b0);
    repeat (8)
    begin
      @(posedge clk_sys);
      upperSizeLog <= 5'h0a + 5'(rnd() % 9);
      lowerSizeLog <= 5'h0a + 5'(rnd() % 9);
      midSizeLog <= 5'h0d + 5'(rnd() % 7);
      r = rnd();
      midBase <= {r[3], 19'h0};
      periphInMem <= r[0];
      sel5IsAddr <= r[1];
      sel6IsAddr <= r[2];
      repeat (25)
      begin
        r = rnd();
        case (r[31:29])
          3'h0, 3'h1: a = 20'hfffff;
          3'h2: a = 20'h0;
          3'h3, 3'h4: a = midBase;
          3'h5, 3'h6: a = periphBase;
          default: a = 20'(rnd());
        endcase
        a = a ^ 20'(r[12:0]);
        if (!r[14])
          a = a & 20'h0ffff;
        step(a, r[14], r[15], r[16] | r[17]);
      end
    end
    // Hold: selects off, latched address pins keep their value
    @(posedge clk_sys);
    sel5IsAddr <= 1;
    sel6IsAddr <= 1;
    step(20'h00006, 1'b1, 1'b0, 1'b1);
    @(posedge clk_sys);
    holdGrant <= 1;
    cycleAddr <= 20'h0;
    cycleStart <= 1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("holdLower", lowerMemSelectN, 1'b1);
    chk("holdPins", {periphSel5Oe, periphSel6Oe, periphSel5OrLatchedAddr1,
        periphSel6OrLatchedAddr2}, 4'hf);
    chk("holdDir", xcvrDirectionOe, 1'b0);
    @(posedge clk_sys);
    holdGrant <= 0;
    cycleStart <= 0;
    sel5IsAddr <= 0;
    extendedMode <= 1;
    coprocReq <= 1;
    coprocErrN <= 0;
    cycleAddr <= midBase | (20'h3 << (midSizeLog - 5'h02));
    repeat (5) @(posedge clk_sys);
    #1;
    chk("req", coprocTransferRequest, 1'b1);
    chk("err", coprocError, 1'b1);
    chk("midOe", midMemSelectOe[1:0], 2'h0);
    chk("nps", midMemSelectN[3], 1'b1);
    @(posedge clk_sys);
    coprocReq <= 0;
    coprocErrN <= 1;
    cycleIsCoproc <= 1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("reqOff", {coprocTransferRequest, coprocError}, 2'h0);
    chk("npsOn", midMemSelectN[3], 1'b0);
    @(posedge clk_sys);
    extendedMode <= 0;
    cycleIsCoproc <= 0;
    cold(1'b1);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("allOe", {upperMemSelectOe, lowerMemSelectOe, midMemSelectOe,
        periphSelectOe, periphSel5Oe, periphSel6Oe, xcvrDirectionOe,
        xcvrOutputEnableOe}, 15'h0);
    cold(1'b0);
    results();
  end
endmodule // tb_chip_select_pins
`default_nettype wire
